// File: design/acmc_pair_dec.sv
// Comparator input routing decode
`timescale 1ns/1ns

module acmc_pair_dec (
	input  wire logic [2:0] pair_sel,    // Comparator pair select
	input  wire logic       mux_borrow,  // Channel mux takes the negative input
	output logic      [1:0] pos_pin,     // Positive pin 0..2
	output logic      [1:0] neg_src      // Negative source code
);

	// Pair table; borrowing keeps only the positive choice from the upper bits
	always_comb begin
		pos_pin = acmc_pkg::NEG_PIN0;
		neg_src = acmc_pkg::NEG_PIN1;
		if (mux_borrow) begin
			neg_src = acmc_pkg::NEG_CHANNEL;
			if (pair_sel[2])
				pos_pin = acmc_pkg::NEG_PIN2;
			else if (pair_sel[1])
				pos_pin = acmc_pkg::NEG_PIN1;
			else
				pos_pin = acmc_pkg::NEG_PIN0;
		end else begin
			unique case (pair_sel)
				3'h0: begin
					pos_pin = acmc_pkg::NEG_PIN0;
					neg_src = acmc_pkg::NEG_PIN1;
				end
				3'h1: begin
					pos_pin = acmc_pkg::NEG_PIN0;
					neg_src = acmc_pkg::NEG_PIN2;
				end
				3'h2: begin
					pos_pin = acmc_pkg::NEG_PIN1;
					neg_src = acmc_pkg::NEG_PIN0;
				end
				3'h3: begin
					pos_pin = acmc_pkg::NEG_PIN1;
					neg_src = acmc_pkg::NEG_PIN2;
				end
				3'h4: begin
					pos_pin = acmc_pkg::NEG_PIN2;
					neg_src = acmc_pkg::NEG_PIN0;
				end
				default: begin
					pos_pin = acmc_pkg::NEG_PIN2;
					neg_src = acmc_pkg::NEG_PIN1;
				end
			endcase
		end
	end

endmodule : acmc_pair_dec

// File: design/acmc_pkg.sv
// Package: register map, field positions, reset values and decode codes
package acmc_pkg;

	// ************************************************************
	// Register offsets (byte addresses on the plain register port)
	// ************************************************************
	localparam logic [7:0] OFF_CONV_MUX    = 8'h07; // converter_mux_register
	localparam logic [7:0] OFF_CMP_CTRL_A  = 8'h08; // comparator mux enable lives here
	localparam logic [7:0] OFF_CMP_CTRL_B  = 8'h09; // comparator_hysteresis_pair_ctrl
	localparam logic [7:0] OFF_CONV_CTRL_A = 8'h06; // converter_control_a
	localparam logic [7:0] OFF_CONV_CTRL_B = 8'h03; // converter_control_b
	localparam logic [7:0] OFF_RES_LOW     = 8'h04; // result_low_byte
	localparam logic [7:0] OFF_RES_HIGH    = 8'h05; // result_high_byte
	localparam logic [7:0] OFF_IRQ_STATUS  = 8'h0a; // sticky event bits, write one to clear
	localparam logic [7:0] OFF_IRQ_MASK    = 8'h0b; // interrupt mask

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int HYST_ON_BIT      = 7;
	localparam int HYST_LEVEL_BIT   = 6;
	localparam int PAIR_SEL_LSB     = 0;
	localparam int CMP_MUX_EN_BIT   = 2;
	localparam int CONV_EN_BIT      = 7;
	localparam int GAIN_SEL_BIT     = 4;
	localparam int LEFT_ADJ_BIT     = 5;
	localparam int CHAN_SEL_LSB     = 0;
	localparam int REF_SEL_LOW_LSB  = 6; // reference bits 1:0 in the mux register
	localparam int REF_SEL_HIGH_BIT = 4; // reference bit 2 in control b
	localparam int IRQ_DONE_BIT     = 0;
	localparam int IRQ_LOST_BIT     = 1;

	// ************************************************************
	// Reset values and codes
	// ************************************************************
	localparam logic [7:0] RST_REG       = 8'h00;
	localparam logic [5:0] CHAN_MAX_PIN  = 6'h0a; // highest pin reachable by the comparator
	localparam logic [5:0] CHAN_TEMP     = 6'h3f; // temperature sensor channel
	localparam logic [5:0] CHAN_DIFF_LO  = 6'h0b; // first differential code
	localparam logic [1:0] NEG_PIN0      = 2'h0;
	localparam logic [1:0] NEG_PIN1      = 2'h1;
	localparam logic [1:0] NEG_PIN2      = 2'h2;
	localparam logic [1:0] NEG_CHANNEL   = 2'h3; // negative input from channel mux
	localparam int         RES_BITS      = 10;

	// Gain choice, pin-level code
	typedef enum logic [1:0] {
		GAIN_X1,
		GAIN_X8,
		GAIN_X20,
		GAIN_X32
	} acmc_gain_e;

endpackage : acmc_pkg

// File: design/acmc_top.sv
// Converter and comparator control: registers, routing, result lock
`timescale 1ns/1ns

// What this block does
// - Mux enable with converter off routes channel pin to comparator negative input
// - Otherwise a dedicated comparator pin drives the negative input
// - Three-bit pair select decodes positive and negative comparator pins
// - Hysteresis-on bit switches comparator hysteresis on or off
// - Hysteresis level bit picks 20mV or 50mV while hysteresis is on
// - Control b: bits 7,6 and 2..0 read/write, bits 5..3 read-only
// - Channel and reference apply only while enabled; no power when disabled
// - Channel code 111111 selects the temperature sensor
// - Ten-bit result in two bytes, right or left adjusted
// - Differential channels get gain 1x/8x/20x/32x; single-ended bypass gain
// - Reading low byte blocks converter writes to both result bytes
// - Conversion finishing while blocked is discarded, bytes unchanged
// - Reading high byte releases the block
// - Completion status bit set on every conversion, even when discarded; irq raised while any set status bit is unmasked
// - Three-bit reference select picks supply, pin, 1.1V or 2.56V
module acmc_top (
	input  wire logic       ref_clk,      // System clock, 20 MHz
	input  wire logic       srst,         // Synchronous reset, active high
	input  wire logic [7:0] reg_addr,     // Register address
	input  wire logic [7:0] reg_wdata,    // Write data
	input  wire logic       reg_wr,       // Write strobe
	input  wire logic       reg_rd,       // Read strobe
	output logic      [7:0] reg_rdata,    // Read data, cycle after strobe
	input  wire logic       conv_done,    // Conversion finished pulse
	input  wire logic [9:0] conv_value,   // Raw result with conv_done
	input  wire logic       cmp_out,      // Comparator output level
	output logic            irq,          // Level interrupt
	output logic      [1:0] cmp_pos_pin,  // Positive pin 0..2
	output logic      [1:0] cmp_neg_src,  // Negative: pin 0..2 or 3 = channel
	output logic      [5:0] cmp_neg_chan, // Analog pin on negative input
	output logic            hyst_on,      // Hysteresis enable
	output logic            hyst_50mv,    // Hysteresis level select
	output logic            conv_power,   // Converter analog power
	output logic      [5:0] conv_chan,    // Applied channel select
	output logic      [2:0] conv_ref,     // Applied reference select
	output logic            temp_sel,     // Temperature sensor on input
	output logic      [1:0] conv_gain,    // Applied gain stage code
	output logic            gain_bypass   // Gain stage bypassed
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [7:0] rdata;
		logic [7:0] mux_reg;
		logic [7:0] cmp_a;
		logic [7:0] cmp_b;
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] res_lo;
		logic [7:0] res_hi;
		logic       locked;
		logic [1:0] status;
		logic [1:0] mask;
		logic       irq;
		logic [1:0] pos;
		logic [1:0] neg;
		logic [5:0] neg_chan;
		logic       hyst_on;
		logic       hyst_lvl;
		logic       power;
		logic [5:0] chan;
		logic [2:0] refs;
		logic       temp;
		logic [1:0] gain;
		logic       bypass;
	} acmc_state_s;

	acmc_state_s st;
	acmc_state_s next_st;
	logic [1:0]  dec_pos;
	logic [1:0]  dec_neg;
	logic        borrow;

	// Gain from channel code and gain bit; single-ended codes bypass
	function automatic logic [1:0] gain_of(input logic [5:0] ch, input logic gain_select);
		logic [1:0] g;
		g = gain_select ? 2'(acmc_pkg::GAIN_X32) : 2'(acmc_pkg::GAIN_X8);
		if (ch[0])
			g = gain_select ? 2'(acmc_pkg::GAIN_X20) : 2'(acmc_pkg::GAIN_X1);
		return g;
	endfunction : gain_of

	// Single-ended or sensor codes skip the amplifier
	function automatic logic is_single(input logic [5:0] ch);
		return (ch < acmc_pkg::CHAN_DIFF_LO) || (ch == acmc_pkg::CHAN_TEMP);
	endfunction : is_single

	// ************************************************************
	// Comparator routing
	// ************************************************************
	assign borrow = st.cmp_a[acmc_pkg::CMP_MUX_EN_BIT]
	                & ~st.ctrl_a[acmc_pkg::CONV_EN_BIT];

	acmc_pair_dec u_pair (
		.pair_sel   (st.cmp_b[2:0]),
		.mux_borrow (borrow),
		.pos_pin    (dec_pos),
		.neg_src    (dec_neg)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [9:0]  res;
		logic [15:0] packed_res;
		logic        en;
		logic [5:0]  ch_wr;
		logic [2:0]  ref_wr;
		res        = conv_value;
		packed_res = 16'h0000;
		en         = 1'b0;
		ch_wr      = 6'h00;
		ref_wr     = 3'h0;
		next_st    = st;

		// Register writes; read-only bits of control b are kept
		if (reg_wr) begin
			unique case (reg_addr)
				acmc_pkg::OFF_CONV_MUX:    next_st.mux_reg = reg_wdata;
				acmc_pkg::OFF_CMP_CTRL_A:  next_st.cmp_a   = reg_wdata;
				acmc_pkg::OFF_CMP_CTRL_B:  next_st.cmp_b   = {reg_wdata[7:6], st.cmp_b[5:3],
				                                             reg_wdata[2:0]};
				acmc_pkg::OFF_CONV_CTRL_A: next_st.ctrl_a  = reg_wdata;
				acmc_pkg::OFF_CONV_CTRL_B: next_st.ctrl_b  = reg_wdata;
				acmc_pkg::OFF_IRQ_MASK:    next_st.mask    = reg_wdata[1:0];
				default: ;
			endcase
		end

		// Read data, one cycle later; unmapped reads as zero
		next_st.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				acmc_pkg::OFF_CONV_MUX:    next_st.rdata = st.mux_reg;
				acmc_pkg::OFF_CMP_CTRL_A:  next_st.rdata = st.cmp_a;
				acmc_pkg::OFF_CMP_CTRL_B:  next_st.rdata = {st.cmp_b[7:6], 3'h0,
				                                             st.cmp_b[2:0]};
				acmc_pkg::OFF_CONV_CTRL_A: next_st.rdata = st.ctrl_a;
				acmc_pkg::OFF_CONV_CTRL_B: next_st.rdata = st.ctrl_b;
				acmc_pkg::OFF_RES_LOW:     next_st.rdata = st.res_lo;
				acmc_pkg::OFF_RES_HIGH:    next_st.rdata = st.res_hi;
				acmc_pkg::OFF_IRQ_STATUS:  next_st.rdata = {6'h00, st.status};
				acmc_pkg::OFF_IRQ_MASK:    next_st.rdata = {6'h00, st.mask};
				default:                   next_st.rdata = 8'h00;
			endcase
			// Low read locks, high read unlocks
			if (reg_addr == acmc_pkg::OFF_RES_LOW)
				next_st.locked = 1'b1;
			if (reg_addr == acmc_pkg::OFF_RES_HIGH)
				next_st.locked = 1'b0;
		end

		// Result capture: alignment chosen at completion time
		if (st.ctrl_a[acmc_pkg::LEFT_ADJ_BIT])
			packed_res = {res, 6'h00};
		else
			packed_res = {6'h00, res};
		if (conv_done && !st.locked) begin
			next_st.res_hi = packed_res[15:8];
			next_st.res_lo = packed_res[7:0];
		end

		// Status: clear by writing one, a same-cycle event wins
		if (reg_wr && reg_addr == acmc_pkg::OFF_IRQ_STATUS)
			next_st.status = st.status & ~reg_wdata[1:0];
		if (conv_done)
			next_st.status[acmc_pkg::IRQ_DONE_BIT] = 1'b1;
		if (conv_done && st.locked)
			next_st.status[acmc_pkg::IRQ_LOST_BIT] = 1'b1;
		next_st.irq = |(next_st.status & next_st.mask);

		// Comparator outputs
		next_st.pos      = dec_pos;
		next_st.neg      = dec_neg;
		next_st.neg_chan = (borrow && st.mux_reg[5:0] <= acmc_pkg::CHAN_MAX_PIN)
		                   ? st.mux_reg[5:0] : 6'h00;
		next_st.hyst_on  = st.cmp_b[acmc_pkg::HYST_ON_BIT];
		next_st.hyst_lvl = st.cmp_b[acmc_pkg::HYST_ON_BIT]
		                   & st.cmp_b[acmc_pkg::HYST_LEVEL_BIT];

		// Converter selections held while disabled
		en             = st.ctrl_a[acmc_pkg::CONV_EN_BIT];
		ch_wr          = st.mux_reg[5:0];
		ref_wr         = {st.ctrl_b[acmc_pkg::REF_SEL_HIGH_BIT], st.mux_reg[7:6]};
		next_st.power  = en;
		if (en) begin
			next_st.chan   = ch_wr;
			next_st.refs   = ref_wr;
			next_st.temp   = (ch_wr == acmc_pkg::CHAN_TEMP);
			next_st.bypass = is_single(ch_wr);
			next_st.gain   = is_single(ch_wr) ? 2'(acmc_pkg::GAIN_X1)
			                 : gain_of(ch_wr, st.ctrl_b[acmc_pkg::GAIN_SEL_BIT]);
		end

		if (srst) begin
			next_st        = '0;
			next_st.bypass = 1'b1;
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		st <= next_st;
	end

	// Outputs straight from flops
	assign reg_rdata    = st.rdata;
	assign irq          = st.irq;
	assign cmp_pos_pin  = st.pos;
	assign cmp_neg_src  = st.neg;
	assign cmp_neg_chan = st.neg_chan;
	assign hyst_on      = st.hyst_on;
	assign hyst_50mv    = st.hyst_lvl;
	assign conv_power   = st.power;
	assign conv_chan    = st.chan;
	assign conv_ref     = st.refs;
	assign temp_sel     = st.temp;
	assign conv_gain    = st.gain;
	assign gain_bypass  = st.bypass;

endmodule : acmc_top

// File: verif/acmc_top_sva.sv
// Checker: port-level properties of the converter and comparator control
`timescale 1ns/1ns

module acmc_top_sva (
	input wire logic       ref_clk,      // Clock
	input wire logic       srst,         // Reset
	input wire logic [7:0] reg_addr,     // Address
	input wire logic [7:0] reg_wdata,    // Write data
	input wire logic       reg_wr,       // Write strobe
	input wire logic       reg_rd,       // Read strobe
	input wire logic [7:0] reg_rdata,    // Read data
	input wire logic [1:0] cmp_pos_pin,  // Positive pin
	input wire logic [1:0] cmp_neg_src,  // Negative source
	input wire logic [5:0] cmp_neg_chan, // Borrowed pin
	input wire logic       hyst_on,      // Hysteresis on
	input wire logic       hyst_50mv,    // Level
	input wire logic       conv_power,   // Power
	input wire logic [5:0] conv_chan,    // Channel
	input wire logic [2:0] conv_ref,     // Reference
	input wire logic       temp_sel      // Sensor
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// Write, and read with its data cycle, of comparator control b
	sequence s_wr_cmp_b;
		reg_wr && reg_addr == acmc_pkg::OFF_CMP_CTRL_B;
	endsequence
	sequence s_rd_cmp_b;
		reg_rd && reg_addr == acmc_pkg::OFF_CMP_CTRL_B ##1 1'b1;
	endsequence

	a_reserved_zero: assert property (s_rd_cmp_b |-> reg_rdata[5:3] == 3'h0)
		else $error("reserved bits read nonzero");
	a_hyst_switch: assert property (s_wr_cmp_b |-> ##2 hyst_on == $past(reg_wdata[7], 2))
		else $error("hysteresis enable wrong");
	a_hyst_level: assert property (s_wr_cmp_b |-> ##2
		hyst_50mv == ($past(reg_wdata[7], 2) && $past(reg_wdata[6], 2)))
		else $error("hysteresis level wrong");
	a_borrow_route: assert property (cmp_neg_src == acmc_pkg::NEG_CHANNEL
		|-> !conv_power && cmp_neg_chan <= acmc_pkg::CHAN_MAX_PIN)
		else $error("channel borrowed while converter on");
	a_dedicated_neg: assert property (cmp_neg_src != acmc_pkg::NEG_CHANNEL
		|-> cmp_neg_chan == 6'h00)
		else $error("channel pin shown without borrowing");
	// Skip two cycles after reset: negative source settles one cycle late
	a_pins_differ: assert property (!$past(srst) && !$past(srst, 2)
		&& cmp_neg_src != acmc_pkg::NEG_CHANNEL |-> cmp_pos_pin != cmp_neg_src)
		else $error("same pin on both comparator inputs");
	a_chan_hold: assert property (!$past(srst) && !conv_power
		|-> $stable(conv_chan) && $stable(conv_ref))
		else $error("selection changed while converter off");
	a_temp_match: assert property (temp_sel == (conv_chan == acmc_pkg::CHAN_TEMP))
		else $error("sensor select disagrees with channel");
endmodule : acmc_top_sva

bind acmc_top acmc_top_sva i_sva (
	.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_pos_pin,
	.cmp_neg_src, .cmp_neg_chan, .hyst_on, .hyst_50mv, .conv_power, .conv_chan,
	.conv_ref, .temp_sel
);

// File: verif/tb_acmc_top.sv
// Testbench: routing table, register access, selections, result lock
`timescale 1ns/1ns

module tb_acmc_top;
	// Routing case: settings beside the expected comparator inputs
	typedef struct packed {
		logic       mux_en;
		logic       conv_en;
		logic [5:0] chan;
		logic [2:0] pair;
		logic [1:0] pos;
		logic [1:0] neg;
		logic [5:0] nch;
	} acmc_row_s;

	logic       ref_clk, srst, reg_wr, reg_rd, conv_done, irq, hyst_on, hyst_50mv;
	logic       conv_power, temp_sel, gain_bypass;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [9:0] conv_value;
	logic [1:0] cmp_pos_pin, cmp_neg_src, conv_gain;
	logic [5:0] cmp_neg_chan, conv_chan;
	logic [2:0] conv_ref;
	int         fail_count, comparisons, cycles;
	logic [7:0] hv [3] = '{8'h80, 8'h40, 8'hff};
	acmc_row_s  rows [12] = '{
		'{1'b0, 1'b0, 6'h00, 3'h0, 2'h0, 2'h1, 6'h00},
		'{1'b0, 1'b0, 6'h05, 3'h1, 2'h0, 2'h2, 6'h00},
		'{1'b0, 1'b0, 6'h00, 3'h2, 2'h1, 2'h0, 6'h00},
		'{1'b0, 1'b1, 6'h00, 3'h3, 2'h1, 2'h2, 6'h00},
		'{1'b0, 1'b0, 6'h00, 3'h4, 2'h2, 2'h0, 6'h00},
		'{1'b0, 1'b0, 6'h00, 3'h5, 2'h2, 2'h1, 6'h00},
		'{1'b0, 1'b1, 6'h00, 3'h6, 2'h2, 2'h1, 6'h00},
		'{1'b0, 1'b0, 6'h00, 3'h7, 2'h2, 2'h1, 6'h00},
		'{1'b1, 1'b1, 6'h05, 3'h0, 2'h0, 2'h1, 6'h00},
		'{1'b1, 1'b0, 6'h00, 3'h0, 2'h0, 2'h3, 6'h00},
		'{1'b1, 1'b0, 6'h0a, 3'h3, 2'h1, 2'h3, 6'h0a},
		'{1'b1, 1'b0, 6'h05, 3'h6, 2'h2, 2'h3, 6'h05}};

	// cmp_out feeds no logic, so it is the only tied input
	acmc_top i_dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.conv_done, .conv_value, .cmp_out(1'b0), .irq, .cmp_pos_pin, .cmp_neg_src,
		.cmp_neg_chan, .hyst_on, .hyst_50mv, .conv_power, .conv_chan, .conv_ref,
		.temp_sel, .conv_gain, .gain_bypass);

	// Clock at 50 ns; cycle ceiling against hangs
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(what, exp, reg_rdata);
	endtask : rd
	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle
	// Value is inverted after the pulse so a late capture shows
	task automatic conv(input logic [9:0] v);
		@(posedge ref_clk);
		conv_done  <= 1'b1;
		conv_value <= v;
		@(posedge ref_clk);
		conv_done  <= 1'b0;
		conv_value <= ~v;
		settle();
	endtask : conv
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	// ********
	// Stimulus
	// ********
	initial begin
		srst       = 1'b1;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		conv_done  = 1'b0;
		reg_addr   = 8'h00;
		reg_wdata  = 8'h00;
		conv_value = 10'h000;
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		#1 chk("bypass at reset", 1'b1, gain_bypass);
		rd(acmc_pkg::OFF_CMP_CTRL_B, 8'h00, "control b reset");
		foreach (rows[i]) begin
			wr(acmc_pkg::OFF_CONV_CTRL_A, {rows[i].conv_en, 7'h00});
			wr(acmc_pkg::OFF_CONV_MUX, {2'h0, rows[i].chan});
			wr(acmc_pkg::OFF_CMP_CTRL_A, {5'h00, rows[i].mux_en, 2'h0});
			wr(acmc_pkg::OFF_CMP_CTRL_B, {5'h00, rows[i].pair});
			settle();
			chk("positive pin", rows[i].pos, cmp_pos_pin);
			chk("negative source", rows[i].neg, cmp_neg_src);
			chk("negative pin", rows[i].nch, cmp_neg_chan);
			chk("power", rows[i].conv_en, conv_power);
		end
		foreach (hv[i]) begin
			wr(acmc_pkg::OFF_CMP_CTRL_B, hv[i]);
			settle();
			chk("hysteresis on", hv[i][7], hyst_on);
			chk("hysteresis level", hv[i][7] & hv[i][6], hyst_50mv);
		end
		rd(acmc_pkg::OFF_CMP_CTRL_B, 8'hc7, "control b read back");
		wr(8'h3c, 8'hff);
		rd(8'h3c, 8'h00, "unmapped");
		// Selections written while off must wait for the enable
		wr(acmc_pkg::OFF_CONV_MUX, 8'hff);
		wr(acmc_pkg::OFF_CONV_CTRL_B, 8'h10);
		settle();
		chk("channel held", 6'h05, conv_chan);
		chk("reference held", 3'h0, conv_ref);
		wr(acmc_pkg::OFF_CONV_CTRL_A, 8'h80);
		settle();
		chk("sensor", 1'b1, temp_sel);
		chk("reference", 3'h7, conv_ref);
		wr(acmc_pkg::OFF_CONV_MUX, 8'h0c);
		settle();
		chk("gain", 2'h3, conv_gain);
		chk("gain in use", 1'b0, gain_bypass);
		// Odd differential code with gain bit set, then both codes with it clear
		wr(acmc_pkg::OFF_CONV_MUX, 8'h0d);
		settle();
		chk("gain 20x", 2'h2, conv_gain);
		wr(acmc_pkg::OFF_CONV_CTRL_B, 8'h00);
		settle();
		chk("gain 1x", 2'h0, conv_gain);
		chk("gain 1x in use", 1'b0, gain_bypass);
		wr(acmc_pkg::OFF_CONV_MUX, 8'h0c);
		settle();
		chk("gain 8x", 2'h1, conv_gain);
		chk("reference supply", 3'h0, conv_ref);
		wr(acmc_pkg::OFF_CONV_MUX, 8'h05);
		settle();
		chk("single ended", 1'b1, gain_bypass);
		wr(acmc_pkg::OFF_CONV_CTRL_A, 8'h00);
		// Lock: low read blocks, a finished conversion is lost
		wr(acmc_pkg::OFF_IRQ_MASK, 8'h01);
		conv(10'h2a5);
		chk("irq", 1'b1, irq);
		rd(acmc_pkg::OFF_RES_LOW, 8'ha5, "low byte");
		conv(10'h15a);
		rd(acmc_pkg::OFF_RES_HIGH, 8'h02, "high while blocked");
		rd(acmc_pkg::OFF_IRQ_STATUS, 8'h03, "status");
		wr(acmc_pkg::OFF_IRQ_STATUS, 8'h03);
		settle();
		chk("irq cleared", 1'b0, irq);
		conv(10'h15a);
		rd(acmc_pkg::OFF_RES_LOW, 8'h5a, "low released");
		rd(acmc_pkg::OFF_RES_HIGH, 8'h01, "high released");
		wr(acmc_pkg::OFF_IRQ_MASK, 8'h00);
		wr(acmc_pkg::OFF_IRQ_STATUS, 8'h01);
		wr(acmc_pkg::OFF_CONV_CTRL_A, 8'h20);
		conv(10'h2a5);
		chk("irq masked", 1'b0, irq);
		rd(acmc_pkg::OFF_RES_LOW, 8'h40, "left low");
		rd(acmc_pkg::OFF_RES_HIGH, 8'ha9, "left high");
		wr(acmc_pkg::OFF_IRQ_MASK, 8'h01);
		settle();
		chk("irq unmasked", 1'b1, irq);
		// Left adjusted, high byte only: no lock is taken, each result lands
		conv(10'h15a);
		rd(acmc_pkg::OFF_RES_HIGH, 8'h56, "high only");
		conv(10'h0ff);
		rd(acmc_pkg::OFF_RES_HIGH, 8'h3f, "high only again");
		// Reset in mid-run: one cycle, then irq, bypass, hysteresis, power, control b and result high back to idle values
		@(posedge ref_clk);
		srst <= 1'b1;
		@(posedge ref_clk);
		srst <= 1'b0;
		#1 chk("irq after reset", 1'b0, irq);
		chk("bypass after reset", 1'b1, gain_bypass);
		chk("hysteresis after reset", 1'b0, hyst_on);
		chk("power after reset", 1'b0, conv_power);
		rd(acmc_pkg::OFF_CMP_CTRL_B, 8'h00, "control b after reset");
		rd(acmc_pkg::OFF_RES_HIGH, 8'h00, "result after reset");
		complete_run();
	end
endmodule : tb_acmc_top
